// *** logic/bcm_consts.svh ***
// Timing counts, limits and reset values for the buck control block
`ifndef BCM_CONSTS_SVH
`define BCM_CONSTS_SVH

`define BCM_CLK_PERIOD_NS   25
`define BCM_MEAS_TIME_NS    50000
// Longest time: round down to whole cycles, 2000 here
`define BCM_MEAS_CYC        ((`BCM_MEAS_TIME_NS) / (`BCM_CLK_PERIOD_NS))
`define BCM_OTP_LOAD_CYC    16
`define BCM_DET_WIN_CYC     320
`define BCM_DET_WIN_US      8
`define BCM_LOAD_LSB_MA     20
`define BCM_RESULT_MAX      9'h1ff
`define BCM_NOM_MIN         5'h01
`define BCM_NOM_MAX         5'h18
`define BCM_TOL_LO_PCT      70
`define BCM_TOL_HI_PCT      110
`define BCM_FPWM_RST        1'b0

`endif

// *** logic/bcm_pkg.sv ***
// Types shared by the buck control block
`default_nettype none
package bcm_pkg;

    // Gray coded along power-up: por, otp load, standby, active
    typedef enum logic [1:0] {
        BCM_ST_POR     = 2'b00,
        BCM_ST_OTP     = 2'b01,
        BCM_ST_STANDBY = 2'b11,
        BCM_ST_ACTIVE  = 2'b10
    } bcm_state_t;

endpackage : bcm_pkg
`default_nettype wire

// *** logic/bcm_ctrl.sv ***
// Load current meter, sync clock control and power-up for the buck pair
//
// Operation
// - One select bit picks which buck core gets its load measured.
// - Each write of the selection launches a fresh measurement.
// - Measured core forced to fixed-frequency mode while measuring.
// - A measurement ends within fifty microseconds of its write.
// - Finished measurement sets done flag; a mask bit suppresses its interrupt.
// - Nine-bit result: low eight bits and top bit on separate outputs.
// - Each result count stands for twenty milliamperes.
// - Spread spectrum on both cores only with PLL off and enable set.
// - PLL off: detector idle, no clock interrupt, internal clock used.
// - PLL on, clock pin not a general output: detector runs, interrupt when external clock comes or goes.
// - PLL on: switch to external clock while valid, else internal.
// - A mask bit suppresses the sync clock interrupt.
// - Five-bit nominal frequency field, 1 to 24 MHz in 1 MHz steps.
// - Valid only within minus thirty, plus ten percent of nominal.
// - PLL on: missing clock raises interrupt entering standby from OTP load, or entering active.
// - Supply good: reset, load defaults, enable serial port, standby.
// - Forced-PWM defaults load from one-time bits; software overrides.
// - Forced PWM keeps fixed frequency; otherwise automatic PWM/PFM.
// - Clock input pin may act as a second general output.
// - Each general output selectable open-drain or push-pull.
`include "bcm_consts.svh"
`default_nettype none

module bcm_ctrl (
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    // Supply and sequencing
    input  wire logic                supply_ok_i,
    input  wire logic                buck_enable_i,
    input  wire logic                otp_fpwm_a_i,
    input  wire logic                otp_fpwm_b_i,
    output logic                     serial_if_en_o,
    output bcm_pkg::bcm_state_t      power_state_o,
    // Forced PWM control
    input  wire logic                fpwm_wr_i,
    input  wire logic                fpwm_a_i,
    input  wire logic                fpwm_b_i,
    output logic                     fpwm_core_a_o,
    output logic                     fpwm_core_b_o,
    // Load current measurement
    input  wire logic                meas_sel_wr_i,
    input  wire logic                meas_sel_i,
    input  wire logic [13:0]         load_current_ma_i,
    output logic                     meas_busy_o,
    output logic [7:0]               load_result_low_o,
    output logic                     load_result_msb_o,
    // Clock synchronisation
    input  wire logic                pll_enable_i,
    input  wire logic                freq_spread_enable_i,
    input  wire logic [4:0]          ext_clock_nominal_freq_i,
    input  wire logic                ext_clock_input_pin_i,
    output logic                     ext_clock_valid_o,
    output logic                     ext_clock_select_o,
    output logic                     spread_active_o,
    // Interrupt flags and masks
    input  wire logic                meas_done_clear_i,
    input  wire logic                sync_clk_clear_i,
    input  wire logic                meas_done_irq_mask_i,
    input  wire logic                sync_clk_irq_mask_i,
    output logic                     meas_done_flag_o,
    output logic                     sync_clk_flag_o,
    output logic                     irq_o,
    // General outputs
    input  wire logic                gpo1_value_i,
    input  wire logic                gpo1_open_drain_i,
    input  wire logic                general_output_two_mode_i,
    input  wire logic                general_output_two_value_i,
    input  wire logic                general_output_two_open_drain_i,
    output logic                     general_output_one_o,
    output logic                     general_output_one_oe_o,
    output logic                     general_output_two_o,
    output logic                     general_output_two_oe_o
);
    import bcm_pkg::*;

    localparam int MEAS_CYC = `BCM_MEAS_CYC;
    localparam int WIN_CYC  = `BCM_DET_WIN_CYC;

    // -------------------------------------------------------------------
    // Helper functions
    // -------------------------------------------------------------------
    // Milliamperes to 20 mA counts, saturating at the top code
    function automatic logic [8:0] ma_to_code(input logic [13:0] ma);
        logic [13:0] q;
        q = ma / 14'(`BCM_LOAD_LSB_MA);
        return (q > 14'(`BCM_RESULT_MAX)) ? `BCM_RESULT_MAX : q[8:0];
    endfunction : ma_to_code

    // Edge-count limit for a nominal frequency and a tolerance percent
    function automatic logic [8:0] edge_limit(input logic [4:0] nom,
                                              input int pct,
                                              input logic round_up);
        int n;
        n = int'(nom) * `BCM_DET_WIN_US * pct;
        return 9'((n + (round_up ? 99 : 0)) / 100);
    endfunction : edge_limit

    // Open-drain drives low only; push-pull drives both levels
    function automatic logic [1:0] pin_drive(input logic val,
                                             input logic od,
                                             input logic en);
        return {en & (od ? ~val : 1'b1), od ? 1'b0 : val};
    endfunction : pin_drive

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    logic       supply_meta_reg;
    logic       supply_sync_reg;
    logic       clk_meta_reg;
    logic       clk_sync_reg;
    logic       clk_prev_reg;

    // Both pins come from outside this clock domain
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            supply_meta_reg <= 1'b0;
            supply_sync_reg <= 1'b0;
            clk_meta_reg    <= 1'b0;
            clk_sync_reg    <= 1'b0;
            clk_prev_reg    <= 1'b0;
        end else begin
            supply_meta_reg <= supply_ok_i;
            supply_sync_reg <= supply_meta_reg;
            clk_meta_reg    <= ext_clock_input_pin_i;
            clk_sync_reg    <= clk_meta_reg;
            clk_prev_reg    <= clk_sync_reg;
        end
    end

    // -------------------------------------------------------------------
    // Power-up sequencer
    // -------------------------------------------------------------------
    bcm_state_t state_reg;
    bcm_state_t state_next;
    logic [4:0] otp_cnt_reg;
    wire        otp_done      = (otp_cnt_reg == 5'(`BCM_OTP_LOAD_CYC - 1));
    wire        enter_standby = (state_reg == BCM_ST_OTP) && otp_done;
    wire        enter_active  = (state_reg == BCM_ST_STANDBY) && buck_enable_i;

    // Supply loss from any state drops back to reset
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            BCM_ST_POR:     if (supply_sync_reg) state_next = BCM_ST_OTP;
            BCM_ST_OTP:     if (otp_done) state_next = BCM_ST_STANDBY;
            BCM_ST_STANDBY: if (buck_enable_i) state_next = BCM_ST_ACTIVE;
            BCM_ST_ACTIVE:  if (!buck_enable_i) state_next = BCM_ST_STANDBY;
        endcase
        if (!supply_sync_reg) state_next = BCM_ST_POR;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_reg   <= BCM_ST_POR;
            otp_cnt_reg <= 5'h00;
        end else begin
            state_reg   <= state_next;
            otp_cnt_reg <= (state_reg == BCM_ST_OTP) ? otp_cnt_reg + 5'h01
                                                     : 5'h00;
        end
    end

    // -------------------------------------------------------------------
    // Forced PWM defaults and software override
    // -------------------------------------------------------------------
    logic fpwm_a_reg;
    logic fpwm_b_reg;

    // Defaults are caught when the one-time bits are read, after reset
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            fpwm_a_reg <= `BCM_FPWM_RST;
            fpwm_b_reg <= `BCM_FPWM_RST;
        end else if (enter_standby) begin
            fpwm_a_reg <= otp_fpwm_a_i;
            fpwm_b_reg <= otp_fpwm_b_i;
        end else if (fpwm_wr_i && state_reg[1]) begin
            fpwm_a_reg <= fpwm_a_i;
            fpwm_b_reg <= fpwm_b_i;
        end
    end

    // -------------------------------------------------------------------
    // Load current measurement
    // -------------------------------------------------------------------
    logic        busy_reg;
    logic        sel_reg;
    logic [10:0] meas_cnt_reg;
    logic [8:0]  result_reg;
    wire         meas_end = busy_reg && !meas_sel_wr_i
                            && (meas_cnt_reg == 11'(MEAS_CYC - 1));

    // A write during a run restarts it on the new core
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            busy_reg     <= 1'b0;
            sel_reg      <= 1'b0;
            meas_cnt_reg <= 11'h000;
            result_reg   <= 9'h000;
        end else if (meas_sel_wr_i) begin
            busy_reg     <= 1'b1;
            sel_reg      <= meas_sel_i;
            meas_cnt_reg <= 11'h000;
        end else if (meas_end) begin
            busy_reg     <= 1'b0;
            result_reg   <= ma_to_code(load_current_ma_i);
        end else if (busy_reg) begin
            meas_cnt_reg <= meas_cnt_reg + 11'h001;
        end
    end

    // -------------------------------------------------------------------
    // External clock detector
    // -------------------------------------------------------------------
    logic [8:0] win_cnt_reg;
    logic [8:0] edge_cnt_reg;
    logic       valid_reg;
    wire        det_on    = pll_enable_i && !general_output_two_mode_i;
    wire        clk_rise  = clk_sync_reg && !clk_prev_reg;
    wire        win_end   = (win_cnt_reg == 9'(WIN_CYC - 1));
    wire        nom_ok    = (ext_clock_nominal_freq_i >= `BCM_NOM_MIN)
                            && (ext_clock_nominal_freq_i <= `BCM_NOM_MAX);
    wire [8:0]  lim_lo    = edge_limit(ext_clock_nominal_freq_i,
                                       `BCM_TOL_LO_PCT, 1'b1);
    wire [8:0]  lim_hi    = edge_limit(ext_clock_nominal_freq_i,
                                       `BCM_TOL_HI_PCT, 1'b0);
    wire        in_band   = nom_ok && (edge_cnt_reg >= lim_lo)
                            && (edge_cnt_reg <= lim_hi);
    wire        valid_chg = det_on && win_end && (in_band != valid_reg);

    // Window timed by the internal clock; verdict only at window end
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !det_on) begin
            win_cnt_reg  <= 9'h000;
            edge_cnt_reg <= 9'h000;
            valid_reg    <= 1'b0;
        end else if (win_end) begin
            win_cnt_reg  <= 9'h000;
            edge_cnt_reg <= 9'h000;
            valid_reg    <= in_band;
        end else begin
            win_cnt_reg  <= win_cnt_reg + 9'h001;
            edge_cnt_reg <= edge_cnt_reg + {8'h00, clk_rise};
        end
    end

    // -------------------------------------------------------------------
    // Interrupt flags
    // -------------------------------------------------------------------
    logic meas_flag_reg;
    logic sync_flag_reg;
    wire  missing  = pll_enable_i && !valid_reg
                     && (enter_standby || enter_active);
    wire  sync_set = valid_chg || missing;

    // Set beats clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            meas_flag_reg <= 1'b0;
            sync_flag_reg <= 1'b0;
        end else begin
            meas_flag_reg <= meas_end
                             || (meas_flag_reg && !meas_done_clear_i);
            sync_flag_reg <= sync_set
                             || (sync_flag_reg && !sync_clk_clear_i);
        end
    end

    // -------------------------------------------------------------------
    // Registered outputs
    // -------------------------------------------------------------------
    wire [1:0] gpo1_drv = pin_drive(gpo1_value_i, gpo1_open_drain_i, 1'b1);
    wire [1:0] general_output_two_drv = pin_drive(general_output_two_value_i, general_output_two_open_drain_i,
                                    general_output_two_mode_i);
    wire       irq_next = (meas_flag_reg && !meas_done_irq_mask_i)
                          || (sync_flag_reg && !sync_clk_irq_mask_i);

    // Every output flopped so nothing glitches toward the pins
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            serial_if_en_o          <= 1'b0;
            power_state_o           <= BCM_ST_POR;
            fpwm_core_a_o           <= 1'b0;
            fpwm_core_b_o           <= 1'b0;
            meas_busy_o             <= 1'b0;
            load_result_low_o       <= 8'h00;
            load_result_msb_o       <= 1'b0;
            ext_clock_valid_o       <= 1'b0;
            ext_clock_select_o      <= 1'b0;
            spread_active_o         <= 1'b0;
            meas_done_flag_o        <= 1'b0;
            sync_clk_flag_o         <= 1'b0;
            irq_o                   <= 1'b0;
            general_output_one_o    <= 1'b0;
            general_output_one_oe_o <= 1'b0;
            general_output_two_o    <= 1'b0;
            general_output_two_oe_o <= 1'b0;
        end else begin
            serial_if_en_o          <= state_reg[1];
            power_state_o           <= state_reg;
            fpwm_core_a_o           <= fpwm_a_reg
                                       || (busy_reg && !sel_reg);
            fpwm_core_b_o           <= fpwm_b_reg
                                       || (busy_reg && sel_reg);
            meas_busy_o             <= busy_reg;
            load_result_low_o       <= result_reg[7:0];
            load_result_msb_o       <= result_reg[8];
            ext_clock_valid_o       <= valid_reg;
            ext_clock_select_o      <= det_on && valid_reg;
            spread_active_o         <= !pll_enable_i
                                       && freq_spread_enable_i;
            meas_done_flag_o        <= meas_flag_reg;
            sync_clk_flag_o         <= sync_flag_reg;
            irq_o                   <= irq_next;
            general_output_one_o    <= gpo1_drv[0];
            general_output_one_oe_o <= gpo1_drv[1];
            general_output_two_o    <= general_output_two_drv[0];
            general_output_two_oe_o <= general_output_two_drv[1];
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    property p_sel_pick;
        @(posedge clk_i) disable iff (!reset_n_i)
        meas_sel_wr_i |=> ##1 (fpwm_core_b_o == (sel_reg | fpwm_b_reg))
                          && (fpwm_core_a_o == (!sel_reg | fpwm_a_reg));
    endproperty
    a_sel_pick: assert property (p_sel_pick)
        else $error("selected core not forced during measurement");

    property p_launch;
        @(posedge clk_i) disable iff (!reset_n_i)
        meas_sel_wr_i |=> busy_reg && (meas_cnt_reg == 11'h000);
    endproperty
    a_launch: assert property (p_launch)
        else $error("write did not start a measurement");

    property p_force;
        @(posedge clk_i) disable iff (!reset_n_i)
        busy_reg && !sel_reg |=> fpwm_core_a_o;
    endproperty
    a_force: assert property (p_force)
        else $error("core a not forced while measured");

    property p_duration;
        @(posedge clk_i) disable iff (!reset_n_i)
        busy_reg |-> meas_cnt_reg < 11'(MEAS_CYC);
    endproperty
    a_duration: assert property (p_duration)
        else $error("measurement ran past its limit");

    property p_done_flag;
        @(posedge clk_i) disable iff (!reset_n_i)
        $fell(busy_reg) && !$past(meas_sel_wr_i) |-> meas_flag_reg
            ##1 meas_done_flag_o;
    endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("done flag missing after measurement");

    property p_result;
        @(posedge clk_i) disable iff (!reset_n_i)
        meas_end |=> ##1 {load_result_msb_o, load_result_low_o}
                         == ma_to_code($past(load_current_ma_i, 2));
    endproperty
    a_result: assert property (p_result)
        else $error("result not in 20 mA counts");

    property p_spread;
        @(posedge clk_i) disable iff (!reset_n_i)
        pll_enable_i |=> !spread_active_o;
    endproperty
    a_spread: assert property (p_spread)
        else $error("spread active with PLL on");

    property p_pll_off;
        @(posedge clk_i) disable iff (!reset_n_i)
        !pll_enable_i [*2] |-> !valid_reg && !sync_set ##1 !ext_clock_select_o;
    endproperty
    a_pll_off: assert property (p_pll_off)
        else $error("detector active with PLL off");

    property p_mask;
        @(posedge clk_i) disable iff (!reset_n_i)
        sync_clk_irq_mask_i && meas_done_irq_mask_i |=> !irq_o;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked flag raised interrupt");

    property p_sticky;
        @(posedge clk_i) disable iff (!reset_n_i)
        sync_flag_reg && !sync_clk_clear_i |=> sync_flag_reg;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("sync flag dropped without clear");

endmodule : bcm_ctrl
`default_nettype wire

// *** verification/bcm_clk_src.sv ***
// External sync clock source that drives the clock input pin
`default_nettype none
module bcm_clk_src (
    input  wire logic run_i,
    output var  logic pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Toggles at 5 MHz only while running; stands still between bursts
    initial pin_o = 1'b0;
    always #100 if (run_i) pin_o = ~pin_o;
endmodule : bcm_clk_src
`default_nettype wire

// *** verification/bcm_ctrl_bench.sv ***
// Self-checking bench for the buck control block
`default_nettype none
module bcm_ctrl_bench;
    import bcm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, reset_n_i = 1'b0, supply_ok_i = 1'b1, clk_run = 1'b0;
    logic buck_enable_i = 1'b0, otp_fpwm_a_i = 1'b1, otp_fpwm_b_i = 1'b0;
    logic fpwm_wr_i = 1'b0, fpwm_a_i = 1'b0, fpwm_b_i = 1'b0, fa, fb;
    logic meas_sel_wr_i = 1'b0, meas_sel_i = 1'b0, ext_clock_input_pin_i;
    logic [13:0] load_current_ma_i = 14'h0000;
    logic pll_enable_i = 1'b0, freq_spread_enable_i = 1'b0;
    logic [4:0] ext_clock_nominal_freq_i = 5'h05;
    logic meas_done_clear_i = 1'b0, sync_clk_clear_i = 1'b0;
    logic meas_done_irq_mask_i = 1'b0, sync_clk_irq_mask_i = 1'b1;
    logic gpo1_value_i = 1'b0, gpo1_open_drain_i = 1'b0, general_output_two_mode_i = 1'b0;
    logic general_output_two_value_i = 1'b0, general_output_two_open_drain_i = 1'b0;
    logic serial_if_en_o, fpwm_core_a_o, fpwm_core_b_o, meas_busy_o;
    logic [7:0] load_result_low_o;
    logic load_result_msb_o, ext_clock_valid_o, ext_clock_select_o;
    logic spread_active_o, meas_done_flag_o, sync_clk_flag_o, irq_o;
    logic general_output_one_o, general_output_one_oe_o;
    logic general_output_two_o, general_output_two_oe_o;
    bcm_state_t power_state_o;
    int err_count = 0, comparisons = 0, cycles = 0, seed = 32'h051c;
    int ld, lo, hi, ev, pv;
    int noms[6] = '{5, 6, 4, 5, 5, 24};
    bit runs[6] = '{1, 1, 1, 1, 0, 1};

    bcm_ctrl DUT (.clk_i, .reset_n_i, .supply_ok_i, .buck_enable_i,
        .otp_fpwm_a_i, .otp_fpwm_b_i, .serial_if_en_o, .power_state_o,
        .fpwm_wr_i, .fpwm_a_i, .fpwm_b_i, .fpwm_core_a_o, .fpwm_core_b_o,
        .meas_sel_wr_i, .meas_sel_i, .load_current_ma_i, .meas_busy_o,
        .load_result_low_o, .load_result_msb_o, .pll_enable_i,
        .freq_spread_enable_i, .ext_clock_nominal_freq_i,
        .ext_clock_input_pin_i, .ext_clock_valid_o, .ext_clock_select_o,
        .spread_active_o, .meas_done_clear_i, .sync_clk_clear_i,
        .meas_done_irq_mask_i, .sync_clk_irq_mask_i, .meas_done_flag_o,
        .sync_clk_flag_o, .irq_o, .gpo1_value_i, .gpo1_open_drain_i,
        .general_output_two_mode_i, .general_output_two_value_i, .general_output_two_open_drain_i,
        .general_output_one_o, .general_output_one_oe_o,
        .general_output_two_o, .general_output_two_oe_o);
    bcm_clk_src u_src (.run_i(clk_run), .pin_o(ext_clock_input_pin_i));

    // 40 MHz clock and a hang guard
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            err_count++;
            close_out();
        end
    end

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    // One measurement with a random load; a clear first proves the flag clears
    task automatic measure(input logic core, input logic mask);
        pulse(meas_done_clear_i);
        cyc(3);
        chk(meas_done_flag_o, 0);
        meas_sel_i = core;
        meas_done_irq_mask_i = mask;
        ld = {$random(seed)} % 12000;
        load_current_ma_i = ld[13:0];
        pulse(meas_sel_wr_i);
        cyc(10);
        chk(meas_busy_o, 1);
        chk(core ? fpwm_core_b_o : fpwm_core_a_o, 1);
        chk(core ? fpwm_core_a_o : fpwm_core_b_o, core ? fa : fb);
        cyc(1900);
        chk(meas_busy_o, 1);
        cyc(95);
        ev = (ld / 20 > 511) ? 511 : ld / 20;
        chk({load_result_msb_o, load_result_low_o}, ev);
        chk(meas_busy_o, 0);
        chk(meas_done_flag_o, 1);
        chk(irq_o, !mask);
        chk({fpwm_core_a_o, fpwm_core_b_o}, {fa, fb});
        $display("measurement on core %0d done", core);
    endtask : measure

    initial begin
        cyc(12);
        reset_n_i = 1'b1;
        cyc(40);
        chk(power_state_o, BCM_ST_STANDBY);
        chk(serial_if_en_o, 1);
        chk({fpwm_core_a_o, fpwm_core_b_o}, 2'b10);
        cyc(48000);
        {fpwm_a_i, fpwm_b_i, fa, fb} = 4'b0101;
        pulse(fpwm_wr_i);
        cyc(3);
        chk({fpwm_core_a_o, fpwm_core_b_o}, 2'b01);
        $display("power-up done");
        measure(1'b0, 1'b0);
        // Restart: a second write mid-run on the other core
        pulse(meas_sel_wr_i);
        cyc(500);
        measure(1'b1, 1'b0);
        measure(1'b0, 1'b1);
        // Detector off: no verdict, no flag, internal clock
        clk_run = 1'b1;
        pulse(sync_clk_clear_i);
        cyc(1000);
        chk({ext_clock_valid_o, ext_clock_select_o, sync_clk_flag_o}, 0);
        pll_enable_i = 1'b1;
        pv = 0;
        foreach (noms[i]) begin
            ext_clock_nominal_freq_i = noms[i][4:0];
            clk_run = runs[i];
            sync_clk_irq_mask_i = i[0];
            pulse(sync_clk_clear_i);
            cyc(1000);
            lo = (noms[i] * 56 + 9) / 10;
            hi = noms[i] * 88 / 10;
            ev = runs[i] && noms[i] <= 24 && lo <= 40 && hi >= 40;
            chk(ext_clock_valid_o, ev);
            chk(ext_clock_select_o, ev);
            chk(sync_clk_flag_o, ev != pv);
            chk(irq_o, ev != pv && !i[0]);
            pv = ev;
        end
        pulse(sync_clk_clear_i);
        cyc(3);
        buck_enable_i = 1'b1;
        cyc(6);
        chk(power_state_o, BCM_ST_ACTIVE);
        chk(sync_clk_flag_o, 1);
        $display("clock sync done");
        for (int i = 0; i < 4; i++) begin
            {pll_enable_i, freq_spread_enable_i} = i[1:0];
            cyc(3);
            chk(spread_active_o, i == 1);
        end
        for (int i = 0; i < 32; i++) begin
            {general_output_two_mode_i, gpo1_value_i, gpo1_open_drain_i} = i[4:2];
            {general_output_two_value_i, general_output_two_open_drain_i} = i[1:0];
            cyc(3);
            chk(general_output_one_o, !i[2] && i[3]);
            chk(general_output_one_oe_o, !i[2] || !i[3]);
            chk(general_output_two_oe_o, i[4] && !(i[0] && i[1]));
            if (i[4])
                chk(general_output_two_o, !i[0] && i[1]);
        end
        $display("spread and outputs done");
        close_out();
    end
endmodule : bcm_ctrl_bench
`default_nettype wire
